// ### rss_reset_startup_sequencer.v
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Functional notes
// (R1) POR holds reset for power-on plus power-up delay; BOR for power-up delay only.
// (R2) Power-up delay is nominally 64 ms when the regulator enable pin is low.
// (R3) Crystal and secondary sources wait 1024 oscillator periods on a 10-bit counter.
// (R4) PLL modes also wait for lock; fast RC with PLL locks after RC start-up.
// (R5) Fast or low-power RC sources wait their RC start-up time before release.
// (R6) Two-speed start-up always begins on fast RC with its start-up time.
// (R7) Oscillator start-up runs beside reset delays; reset may end first.
// (R8) CPU runs only once a valid clock is released and reset has ended.
// (R9) Clock monitor, if enabled, checks the clock when system reset releases.
// (R10) No valid clock at that moment: fall back to fast RC and raise trap.
// (R11) All registers but four take one reset value for every reset kind.
// (R12) Reset cause register reset value depends on the reset source.
// (R13) Oscillator control reset value depends on reset kind and config select bits.
// (R14) Calibration and flash control registers reset only on power-on reset.
// (R15) Reset forces the fetch address to zero.
// (R16) Reset involves no interrupt controller and fetches no vector.
// (R17) Any active reset source asserts the system reset output.
// (R18) POR and BOR take config select bits; other resets keep current oscillator. The code reloads the select bits on other resets while RSS_CFG_CLKSW is clear.
// (R19) System reset releases only after power-on and power-up delays expire.
// (R20) Pin, software, watchdog and other resets add no power-up delay.
`include "rss_consts.vh"

module rss_reset_startup_sequencer #(
  parameter [31:0] PWRT_CYCLES = `RSS_TPWRT_US * `RSS_CLK_MHZ,
  parameter [31:0] LOW_POWER_INTERNAL_RC_OSC_CYCLES = `RSS_TLPRC_US * `RSS_CLK_MHZ
) (
  // clock and power-on reset
  input  wire        clock,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // reset sources and regulator enable from pins
  input  wire        resetPinN,
  input  wire        brownOutDetect,
  input  wire        regulatorEnablePin,
  // reset sources from core logic
  input  wire        softwareReset,
  input  wire        watchdogTimeout,
  input  wire        trapConflict,
  input  wire        illegalOpcode,
  input  wire        configMismatch,
  // configuration word two and fuses
  input  wire [2:0]  initialOscSelect,
  input  wire        primaryIsCrystal,
  // oscillator circuits
  input  wire        oscClockSample,
  input  wire        pllLocked,
  // towards cpu core and clock mux
  output reg         systemResetOut,
  output reg         clockReleased,
  output reg         cpuRun,
  output reg  [23:0] fetchAddress,
  output reg  [2:0]  activeOscSelect,
  output reg         oscFailTrap
);

  // ***************************************************
  // states and derived cycle counts
  // ***************************************************
  localparam [1:0] RS_HOLD  = 2'h0;
  localparam [1:0] RS_POR   = 2'h1;
  localparam [1:0] RS_PWRT  = 2'h2;
  localparam [1:0] RS_RUN   = 2'h3;
  localparam [1:0] CK_RC    = 2'h0;
  localparam [1:0] CK_OST   = 2'h1;
  localparam [1:0] CK_LOCK  = 2'h2;
  localparam [1:0] CK_READY = 2'h3;

  localparam [31:0] TPOR_CYC     = `RSS_TPOR_US * `RSS_CLK_MHZ;
  localparam [31:0] TPWRT_REGCYC = `RSS_TPWRT_REG_US * `RSS_CLK_MHZ;
  localparam [31:0] TFRC_CYC     = `RSS_TFRC_US * `RSS_CLK_MHZ;

  // ***************************************************
  // pin synchronisation
  // ***************************************************
  wire [4:0] pinStable;
  wire       pinResetActive = ~pinStable[4];
  wire       brownOut       = pinStable[3];
  wire       regulatorOn    = pinStable[2];
  wire       oscLevel       = pinStable[1];
  wire       pllLockStable  = pinStable[0];

  rss_pin_sync #(
    .WIDTH     (5),
    .RESET_VAL (`RSS_SYNC_RESET_VAL)
  ) pinSync (
    .clock     (clock),
    .rst_n     (rst_n),
    .pinIn     ({resetPinN, brownOutDetect, regulatorEnablePin, oscClockSample, pllLocked}),
    .pinStable (pinStable)
  );

  // ***************************************************
  // register state
  // ***************************************************
  reg [1:0]  resetState;
  reg [1:0]  next_resetState;
  reg        kindPor;
  reg        kindBor;
  reg        delayLoad;
  reg [31:0] delayValue;
  wire       delayExpired;
  reg [1:0]  clockState;
  reg        pllMode;
  reg        rcLoad;
  reg [31:0] rcValue;
  wire       rcExpired;
  reg [9:0]  ostCount;
  reg        oscLevelPrev;
  reg [15:0] causeReg;
  reg [2:0]  newOsc;
  reg        oscFailFlag;
  reg [15:0] calReg;
  reg [15:0] flashReg;
  reg [2:0]  cfgReg;
  reg        clockInit;

  // any active reset source
  wire anySource = pinResetActive | brownOut | softwareReset | watchdogTimeout |
                   trapConflict | illegalOpcode | configMismatch;
  wire resetRelease = systemResetOut & (next_resetState == RS_RUN);
  wire fscmFail = resetRelease & cfgReg[`RSS_CFG_FAIL_SAFE_CLOCK_MONITOR] & (clockState != CK_READY); // see (R9)
  wire borStart = brownOut & ~kindBor;
  wire clockKick = clockInit | borStart | fscmFail;
  wire oscEdge = oscLevel & ~oscLevelPrev;
  wire regWrite = write & ~waitrequest;

  // ***************************************************
  // system reset delay sequencing
  // ***************************************************
  // next reset state and delay timer load
  always @* begin
    next_resetState = resetState;
    delayLoad       = 1'b0;
    delayValue      = TPOR_CYC;
    case (resetState)
      RS_HOLD: begin
        if (!anySource) begin
          if (kindPor) begin
            next_resetState = RS_POR;                    // see (R1)
            delayLoad       = 1'b1;
          end else if (kindBor) begin
            next_resetState = RS_PWRT;                   // see (R1)
            delayLoad       = 1'b1;
            delayValue      = regulatorOn ? TPWRT_REGCYC : PWRT_CYCLES; // see (R2)
          end else begin
            next_resetState = RS_RUN;                    // see (R20)
          end
        end
      end
      RS_POR: begin
        if (anySource) begin
          next_resetState = RS_HOLD;
        end else if (delayExpired) begin
          next_resetState = RS_PWRT;                     // see (R19)
          delayLoad       = 1'b1;
          delayValue      = regulatorOn ? TPWRT_REGCYC : PWRT_CYCLES; // see (R2)
        end
      end
      RS_PWRT: begin
        if (anySource) begin
          next_resetState = RS_HOLD;
        end else if (delayExpired) begin
          next_resetState = RS_RUN;                      // see (R19)
        end
      end
      RS_RUN: begin
        if (anySource) begin
          next_resetState = RS_HOLD;                     // see (R17)
        end
      end
      default: begin
        next_resetState = RS_HOLD;
      end
    endcase
  end

  rss_delay_timer resetDelay (
    .clock     (clock),
    .rst_n     (rst_n),
    .load      (delayLoad),
    .loadValue (delayValue[23:0]),
    .expired   (delayExpired)
  );

  // reset state, reset kind and the core-facing outputs
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resetState     <= RS_HOLD;
      kindPor        <= 1'b1;
      kindBor        <= 1'b0;
      systemResetOut <= 1'b1;
      cpuRun         <= 1'b0;
      fetchAddress   <= `RSS_RESET_PC;
      clockInit      <= 1'b1;
    end else begin
      resetState     <= next_resetState;
      systemResetOut <= (next_resetState != RS_RUN);     // see (R17)
      clockInit      <= 1'b0;
      if (next_resetState == RS_RUN) begin
        kindPor <= 1'b0;
        kindBor <= 1'b0;
      end else if (brownOut) begin
        kindBor <= 1'b1;
      end
      // cpu waits for both reset release and a released clock
      cpuRun <= (next_resetState == RS_RUN) & clockReleased & ~fscmFail; // see (R8)
      // reset start is a plain load of the fetch address, not a vector fetch
      if (systemResetOut) begin
        fetchAddress <= `RSS_RESET_PC;                   // see (R15) (R16)
      end
    end
  end

  // ***************************************************
  // oscillator start-up, independent of the reset delays
  // ***************************************************
  // pick the source and the rc start-up wait on a kick
  reg [2:0] kickSrc;
  always @* begin
    if (fscmFail || cfgReg[`RSS_CFG_TWOSPD]) begin
      kickSrc = `RSS_OSC_FRC;                            // see (R6) (R10)
    end else begin
      kickSrc = initialOscSelect;                        // see (R18)
    end
    rcLoad  = clockKick & ((kickSrc == `RSS_OSC_FRC) | (kickSrc == `RSS_OSC_FRCPLL) |
              (kickSrc == `RSS_OSC_FRCDIV) | (kickSrc == `RSS_OSC_LOW_POWER_INTERNAL_RC_OSC));
    rcValue = (kickSrc == `RSS_OSC_LOW_POWER_INTERNAL_RC_OSC) ? LOW_POWER_INTERNAL_RC_OSC_CYCLES : TFRC_CYC; // see (R5)
  end

  rss_delay_timer rcDelay (
    .clock     (clock),
    .rst_n     (rst_n),
    .load      (rcLoad),
    .loadValue (rcValue[23:0]),
    .expired   (rcExpired)
  );

  // clock state machine; it sees the reset delay state only through the monitor check at reset release
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clockState      <= CK_RC;
      pllMode         <= 1'b0;
      ostCount        <= 10'h000;
      oscLevelPrev    <= 1'b0;
      activeOscSelect <= `RSS_OSC_FRC;
      clockReleased   <= 1'b0;
      oscFailTrap     <= 1'b0;
    end else begin
      oscLevelPrev <= oscLevel;
      oscFailTrap  <= fscmFail;                          // see (R10)
      if (clockKick) begin
        activeOscSelect <= kickSrc;                      // see (R18)
        ostCount        <= 10'h000;
        clockReleased   <= 1'b0;
        pllMode         <= (kickSrc == `RSS_OSC_FRCPLL) | (kickSrc == `RSS_OSC_PRIPLL);
        if (rcLoad) begin
          clockState <= CK_RC;                           // see (R5)
        end else if (kickSrc == `RSS_OSC_SOSC || primaryIsCrystal) begin
          clockState <= CK_OST;                          // see (R3)
        end else if (kickSrc == `RSS_OSC_PRIPLL) begin
          clockState <= CK_LOCK;                         // see (R4)
        end else begin
          clockState <= CK_READY;
        end
      end else begin
        if (anySource && !kindPor && !brownOut && !cfgReg[`RSS_CFG_CLKSW]) begin
          activeOscSelect <= initialOscSelect;           // see (R18)
        end
        case (clockState)
          CK_RC: begin
            if (rcExpired) begin
              clockState <= pllMode ? CK_LOCK : CK_READY; // see (R4)
            end
          end
          CK_OST: begin
            if (oscEdge) begin
              ostCount <= ostCount + 10'h001;
              if (ostCount == `RSS_OST_LAST) begin
                clockState <= pllMode ? CK_LOCK : CK_READY; // see (R3)
              end
            end
          end
          CK_LOCK: begin
            if (pllLockStable) begin
              clockState <= CK_READY;                    // see (R4)
            end
          end
          default: begin
            clockState <= CK_READY;
          end
        endcase
        // release may land before or after reset ends
        clockReleased <= (clockState == CK_READY);       // see (R7)
      end
    end
  end

  // ***************************************************
  // avalon-mm slave
  // ***************************************************
  // one wait cycle per access keeps the read mux off the critical path
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read && waitrequest) begin
        case (address)
          `RSS_OFF_CAUSE:  readdata <= {16'h0000, causeReg};
          `RSS_OFF_OSCCTL: readdata <= {17'h00000, activeOscSelect, 1'b0, newOsc, 4'h0,
                                        oscFailFlag, 3'h0};
          `RSS_OFF_CAL:    readdata <= {16'h0000, calReg};
          `RSS_OFF_FLASH:  readdata <= {16'h0000, flashReg};
          `RSS_OFF_CFG:    readdata <= {29'h00000000, cfgReg};
          `RSS_OFF_STAT:   readdata <= {25'h0000000, cpuRun, clockReleased, systemResetOut,
                                        clockState, resetState};
          default:         readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // cause flags: hardware set wins over a software write in the same cycle
  wire [15:0] causeSet = ({15'h0000, kindPor} << `RSS_CAUSE_POR) |
                         ({15'h0000, brownOut | kindPor} << `RSS_CAUSE_BOR) |
                         ({15'h0000, pinResetActive} << `RSS_CAUSE_EXTR) |
                         ({15'h0000, softwareReset} << `RSS_CAUSE_SWR) |
                         ({15'h0000, watchdogTimeout} << `RSS_CAUSE_WDTO) |
                         ({15'h0000, trapConflict} << `RSS_CAUSE_TRAP) |
                         ({15'h0000, illegalOpcode} << `RSS_CAUSE_IOP) |
                         ({15'h0000, configMismatch} << `RSS_CAUSE_CM);

  // reset cause and oscillator control: values depend on the reset kind
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      causeReg    <= `RSS_CAUSE_POR_VAL;                 // see (R12)
      newOsc      <= `RSS_OSC_FRC;
      oscFailFlag <= 1'b0;
    end else begin
      if (regWrite && address == `RSS_OFF_CAUSE) begin
        causeReg <= (writedata[15:0] & `RSS_CAUSE_MASK) | causeSet;
      end else if (systemResetOut) begin
        causeReg <= causeReg | causeSet;                 // see (R12)
      end
      if (fscmFail) begin
        oscFailFlag <= 1'b1;
      end else if (systemResetOut) begin
        oscFailFlag <= 1'b0;
      end else if (regWrite && address == `RSS_OFF_OSCCTL) begin
        oscFailFlag <= writedata[`RSS_OSC_FAIL_BIT];
      end
      if (systemResetOut) begin
        newOsc <= activeOscSelect;                       // see (R13)
      end else if (regWrite && address == `RSS_OFF_OSCCTL) begin
        newOsc <= writedata[`RSS_OSC_NEW_LSB+2:`RSS_OSC_NEW_LSB];
      end
    end
  end

  // configuration: same value after every reset kind
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg <= `RSS_CFG_RESET_VAL;
    end else if (systemResetOut) begin
      cfgReg <= `RSS_CFG_RESET_VAL;                      // see (R11)
    end else if (regWrite && address == `RSS_OFF_CFG) begin
      cfgReg <= writedata[2:0];
    end
  end

  // calibration and flash control survive every reset but power-on
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      calReg   <= 16'h0000;                              // see (R14)
      flashReg <= 16'h0000;                              // see (R14)
    end else begin
      if (regWrite && address == `RSS_OFF_CAL) begin
        calReg <= writedata[15:0];
      end
      if (regWrite && address == `RSS_OFF_FLASH) begin
        flashReg <= writedata[15:0];
      end
    end
  end

endmodule

// ### rss_consts.vh
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// ***************************************************
// timing, clock at 200 MHz
// ***************************************************
`define RSS_CLK_MHZ        200
`define RSS_TPOR_US        10
`define RSS_TPWRT_US       64000
`define RSS_TPWRT_REG_US   10
`define RSS_TFRC_US        15
`define RSS_TLPRC_US       100
`define RSS_OST_LAST       10'h3FF

// ***************************************************
// register byte offsets
// ***************************************************
`define RSS_OFF_CAUSE      5'h00
`define RSS_OFF_OSCCTL     5'h04
`define RSS_OFF_CAL        5'h08
`define RSS_OFF_FLASH      5'h0C
`define RSS_OFF_CFG        5'h10
`define RSS_OFF_STAT       5'h14

// ***************************************************
// reset cause register fields and reset values
// ***************************************************
`define RSS_CAUSE_TRAP     15
`define RSS_CAUSE_IOP      14
`define RSS_CAUSE_CM       9
`define RSS_CAUSE_EXTR     7
`define RSS_CAUSE_SWR      6
`define RSS_CAUSE_WDTO     4
`define RSS_CAUSE_BOR      1
`define RSS_CAUSE_POR      0
`define RSS_CAUSE_POR_VAL  16'h0003
`define RSS_CAUSE_MASK     16'hC3FF

// ***************************************************
// oscillator control fields and source codes
// ***************************************************
`define RSS_OSC_CUR_LSB    12
`define RSS_OSC_NEW_LSB    8
`define RSS_OSC_FAIL_BIT   3
`define RSS_OSC_FRC        3'h0
`define RSS_OSC_FRCPLL     3'h1
`define RSS_OSC_PRI        3'h2
`define RSS_OSC_PRIPLL     3'h3
`define RSS_OSC_SOSC       3'h4
`define RSS_OSC_LOW_POWER_INTERNAL_RC_OSC       3'h5
`define RSS_OSC_FRCDIV     3'h7

// ***************************************************
// configuration register fields, reset fetch address and synchroniser reset value
// ***************************************************
`define RSS_CFG_TWOSPD     0
`define RSS_CFG_FAIL_SAFE_CLOCK_MONITOR       1
`define RSS_CFG_CLKSW      2
`define RSS_CFG_RESET_VAL  3'h6
`define RSS_RESET_PC       24'h000000
`define RSS_SYNC_RESET_VAL 5'h10

`endif

// ### rss_pin_sync.v
`timescale 1ns/1ps
// three-stage synchroniser; a bit changes once stages two and three agree
module rss_pin_sync #(
  parameter       WIDTH     = 5,
  parameter [4:0] RESET_VAL = 5'h00
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst_n,
  // raw pins and filtered levels
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] pinStable
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // stage1 feeds stage2 only, never any logic
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1    <= RESET_VAL[WIDTH-1:0];
      stage2    <= RESET_VAL[WIDTH-1:0];
      stage3    <= RESET_VAL[WIDTH-1:0];
      pinStable <= RESET_VAL[WIDTH-1:0];
    end else begin
      stage1    <= pinIn;
      stage2    <= stage1;
      stage3    <= stage2;
      pinStable <= (stage3 & ~(stage2 ^ stage3)) | (pinStable & (stage2 ^ stage3));
    end
  end

endmodule

// ### rss_delay_timer.v
`timescale 1ns/1ps
// down counter; expired rises loadValue cycles after the load
module rss_delay_timer (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // control
  input  wire        load,
  input  wire [23:0] loadValue,
  // status
  output reg         expired
);

  reg [23:0] count;

  // a load always restarts, so a stale expiry cannot leak into a new wait
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count   <= 24'h000000;
      expired <= 1'b0;
    end else if (load) begin
      count   <= loadValue;
      expired <= 1'b0;
    end else if (count > 24'h000001) begin
      count   <= count - 24'h000001;
    end else begin
      count   <= 24'h000000;
      expired <= 1'b1;
    end
  end

endmodule

// ### rss_assertions.sv
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module rss_checker (
  // clock and reset
  input wire        clock,
  input wire        rst_n,
  // bus handshake
  input wire        read,
  input wire        write,
  input wire        waitrequest,
  // reset sources
  input wire        softwareReset,
  input wire        watchdogTimeout,
  input wire        trapConflict,
  input wire        illegalOpcode,
  input wire        configMismatch,
  input wire        resetPinN,
  input wire        brownOutDetect,
  // core side
  input wire        systemResetOut,
  input wire        clockReleased,
  input wire        cpuRun,
  input wire [23:0] fetchAddress,
  input wire [2:0]  activeOscSelect,
  input wire        oscFailTrap
);
  // same-clock sources seen as one request
  wire anySrc = softwareReset | watchdogTimeout | trapConflict | illegalOpcode | configMismatch;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_src_resets: assert property (anySrc |=> systemResetOut)
    else $error("reset source ignored");
  a_cpu_gated: assert property (cpuRun |-> clockReleased && !systemResetOut)
    else $error("core ran without clock");
  a_fetch_zero: assert property (systemResetOut |-> fetchAddress == 24'h000000)
    else $error("fetch address not zero");
  a_trap_frc: assert property (oscFailTrap |-> activeOscSelect == 3'h0 ##1 !oscFailTrap)
    else $error("trap not on fast rc");
  a_trap_release: assert property (oscFailTrap |-> !systemResetOut && $past(systemResetOut, 2))
    else $error("monitor fired off release");
  a_quick_release: assert property ($fell(anySrc) && clockReleased && resetPinN && !brownOutDetect
    |=> !systemResetOut)
    else $error("late release");
  a_bus_answer: assert property ($rose(read) || $rose(write) |=> !waitrequest)
    else $error("bus answer late");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");

  cover property ($fell(systemResetOut));
  cover property (oscFailTrap);
  cover property ($rose(cpuRun));
endmodule

bind rss_reset_startup_sequencer rss_checker u_rss_checker (.clock, .rst_n, .read, .write, .waitrequest,
  .softwareReset, .watchdogTimeout, .trapConflict, .illegalOpcode, .configMismatch, .resetPinN,
  .brownOutDetect, .systemResetOut, .clockReleased, .cpuRun, .fetchAddress, .activeOscSelect, .oscFailTrap);

// ### rss_osc_model.sv
`timescale 1ns/1ps
// ****************
// crystal and pll
// ****************
module rss_osc_model #(
  parameter LOCK_EDGES = 64
) (
  // supply to the oscillator
  input wire oscOn,
  // towards the sequencer
  output reg oscClockSample,
  output reg pllLocked
);
  integer edges;

  // free running near 45 MHz, no phase tie to the system clock; unpowered it stops low and loses lock
  // each level outlasts two system clocks, so the pin filter sees every edge
  initial begin
    oscClockSample = 1'b0;
    pllLocked = 1'b0;
    edges = 0;
    forever begin
      #11;
      if (oscOn) begin
        oscClockSample = !oscClockSample;
        edges = edges + oscClockSample;
        pllLocked = (edges > LOCK_EDGES);
      end else begin
        oscClockSample = 1'b0;
        pllLocked = 1'b0;
        edges = 0;
      end
    end
  end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  // ****************
  // signals
  // ****************
  reg         clock, rst_n, read, write, resetPinN, brownOutDetect, regulatorEnablePin, primaryIsCrystal, oscOn;
  reg  [4:0]  address, src;
  reg  [31:0] writedata, q, cal;
  reg  [2:0]  initialOscSelect, code;
  reg  [15:0] cause;
  wire [31:0] readdata;
  wire        waitrequest, oscClockSample, pllLocked, systemResetOut, clockReleased, cpuRun, oscFailTrap;
  wire [23:0] fetchAddress;
  wire [2:0]  activeOscSelect;
  wire [3:0]  obs = {oscFailTrap, cpuRun, clockReleased, systemResetOut};
  integer     n_errors, cmp_count, i, n, len;

  rss_reset_startup_sequencer #(.PWRT_CYCLES(5000), .LOW_POWER_INTERNAL_RC_OSC_CYCLES(50)) u_rss_reset_startup_sequencer (
    .clock, .rst_n, .address, .read, .write, .writedata, .readdata, .waitrequest, .resetPinN,
    .brownOutDetect, .regulatorEnablePin, .softwareReset(src[0]), .watchdogTimeout(src[1]),
    .trapConflict(src[2]), .illegalOpcode(src[3]), .configMismatch(src[4]), .initialOscSelect,
    .primaryIsCrystal, .oscClockSample, .pllLocked, .systemResetOut, .clockReleased, .cpuRun,
    .fetchAddress, .activeOscSelect, .oscFailTrap);
  rss_osc_model u_rss_osc_model (.oscOn, .oscClockSample, .pllLocked);

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************
  // helpers
  // ****************
  task end_sim;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task chk(input string what, input [31:0] seen, input [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one avalon transfer; the request stands until waitrequest is seen low
  task bus(input wr, input [4:0] a, input [31:0] d);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clock);
      n = n + 1;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  endtask

  // edges until an observed output reaches lvl; a miss ends the run
  task waitOut(input integer k, input lvl, input integer lim);
    n = 0;
    do begin
      @(posedge clock);
      n = n + 1;
    end while (obs[k] !== lvl && n < lim);
    if (n >= lim) begin
      n_errors = n_errors + 1;
      end_sim;
    end
  endtask

  // cause flag of each same-clock source
  function [15:0] causeBit(input integer k);
    causeBit = (k == 0) ? 16'h0040 : (k == 1) ? 16'h0010 : (k == 2) ? 16'h8000 : (k == 3) ? 16'h4000 : 16'h0200;
  endfunction

  // ****************
  // scenarios
  // ****************
  initial begin
    {read, write, address, writedata, src, brownOutDetect, regulatorEnablePin, rst_n} = 0;
    {resetPinN, primaryIsCrystal, oscOn, initialOscSelect} = 6'h38;
    n_errors = 0;
    cmp_count = 0;
    void'($urandom(32'h1B2E91A9));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    // power-on: the fast rc is ready before the long hold ends, so no trap
    waitOut(0, 1'b0, 7100);
    chk("por hold", n >= 7000 && n <= 7012, 1);
    chk("no trap", oscFailTrap, 0);
    chk("cpu run", cpuRun, 1);
    bus(0, 5'h04, 0);
    chk("fail flag", q[3], 0);
    bus(0, 5'h00, 0);
    chk("por cause", q, 32'h3);
    bus(0, 5'h10, 0);
    chk("cfg reset", q, 32'h6);
    bus(0, 5'h18, 0);
    chk("unmapped", q, 0);
    waitOut(1, 1'b1, 4000);
    waitOut(2, 1'b1, 4);
    chk("fetch", fetchAddress, 0);
    cal = $urandom & 32'hFFFF;
    bus(1, 5'h08, cal);
    // each same-clock source, random length; release one cycle after it drops
    cause = 16'h0003;
    for (i = 0; i < 5; i = i + 1) begin
      len = 2 + $urandom % 7;
      @(posedge clock);
      src[i] <= 1'b1;
      repeat (len) @(posedge clock);
      chk("src reset", systemResetOut, 1);
      src[i] <= 1'b0;
      waitOut(0, 1'b0, 20);
      chk("src release", n, 2);
      cause = cause | causeBit(i);
      bus(0, 5'h00, 0);
      chk("src cause", q, cause);
    end
    // brown-outs over low_power_internal_rc_osc, dead sosc (monitor falls back), crystal pll, then two-speed
    bus(1, 5'h10, 32'h4);
    for (i = 0; i < 4; i = i + 1) begin
      code = 12'h4E5 >> (3 * i);
      if (i == 3) bus(1, 5'h10, 32'h5);
      initialOscSelect <= code;
      brownOutDetect <= 1'b1;
      oscOn <= 1'b0;
      repeat (10) @(posedge clock);
      brownOutDetect <= 1'b0;
      oscOn <= (i != 1);
      len = 0;
      // crystal pll: 1024 periods of 22 ns, then lock, all before the reset ends
      if (i == 2) begin
        waitOut(1, 1'b1, 5100);
        len = n;
        chk("ost wait", len >= 4400, 1);
      end
      waitOut(0, 1'b0, 5100);
      chk("bor hold", len + n >= 5000 && len + n <= 5012, 1);
      chk("bor trap", oscFailTrap, i == 1);
      chk("cpu gated", cpuRun, i != 1);
      chk("bor osc", activeOscSelect, (i % 2) ? 3'h0 : code);
      waitOut(1, 1'b1, 3100);
      if (i == 1) chk("frc restart", n >= 3000 && n <= 3004, 1);
      bus(0, 5'h04, 0);
      chk("bor fail flag", q[3], i == 1);
      bus(0, 5'h08, 0);
      chk("cal kept", q, cal);
      bus(0, 5'h00, 0);
      chk("bor cause", q, cause);
    end
    // pin reset keeps the current oscillator
    @(posedge clock);
    resetPinN <= 1'b0;
    repeat (10) @(posedge clock);
    chk("pin reset", systemResetOut, 1);
    resetPinN <= 1'b1;
    waitOut(0, 1'b0, 30);
    chk("pin osc", activeOscSelect, 0);
    bus(0, 5'h00, 0);
    chk("pin cause", q, cause | 16'h0080);
    // second power-on with the regulator on
    @(posedge clock);
    rst_n <= 1'b0;
    regulatorEnablePin <= 1'b1;
    primaryIsCrystal <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    waitOut(0, 1'b0, 5000);
    chk("reg hold", n >= 4000 && n <= 4012, 1);
    chk("por osc", activeOscSelect, 3'h2);
    bus(0, 5'h00, 0);
    chk("por cause", q, 32'h3);
    end_sim;
  end
endmodule
